// >>> core/ssc_defines.vh
// Constants for the sequence step controller
`ifndef SSC_DEFINES_VH
`define SSC_DEFINES_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define SSC_OFS_CTRL      12'h000
`define SSC_OFS_STATUS    12'h004
`define SSC_OFS_CMD       12'h008
`define SSC_OFS_SEL       12'h00c
`define SSC_OFS_TIME      12'h010
`define SSC_OFS_CFG       12'h014
`define SSC_OFS_PHASE_NOW 12'h018
`define SSC_OFS_ID        12'h01c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define SSC_CTRL_EXT_EN   0
`define SSC_CTRL_SUB_D0   1

// ---------------------------------------------------------------
// Command register bits (write one to act)
// ---------------------------------------------------------------
`define SSC_CMD_START     0
`define SSC_CMD_STOP      1
`define SSC_CMD_HOLD      2
`define SSC_CMD_RESUME    3
`define SSC_CMD_EVENT     4

// ---------------------------------------------------------------
// Step configuration word fields
// ---------------------------------------------------------------
`define SSC_CFG_PAUSE     0
`define SSC_CFG_PHASE_EN  1
`define SSC_CFG_JUMP_EN   2
`define SSC_CFG_CNT_EN    3
`define SSC_CFG_CNT_INF   4
`define SSC_CFG_LVL_EN    5
`define SSC_CFG_EDGE_EN   6
`define SSC_CFG_FIN_END   7
`define SSC_CFG_CODE_LSB  8
`define SSC_CFG_JTGT_LSB  12
`define SSC_CFG_BTGT_LSB  16
`define SSC_CFG_CNT_LSB   20
`define SSC_CFG_PHS_LSB   24

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define SSC_RST_CTRL      2'h0
`define SSC_RST_CFG       32'h00000000
`define SSC_RST_TIME      32'h00000001

`endif

// >>> core/ssc_pin_sync.v
// Three-stage pin synchroniser with agreement filter and edge pulses
`default_nettype none

module ssc_pin_sync
#(
  parameter RESET_LEVEL = 1'b1
)
(
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // Pin side
  input wire pin_i,
  // Filtered level and edges
  output reg level_o,
  output wire fall_o,
  output wire rise_o
);

  reg s1_ff;
  reg s2_ff;
  reg s3_ff;

  // ---------------------------------------------------------------
  // Synchroniser chain
  // ---------------------------------------------------------------
  // Stage one feeds only stage two; filter looks at stages two and three
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      s1_ff <= RESET_LEVEL;
      s2_ff <= RESET_LEVEL;
      s3_ff <= RESET_LEVEL;
      level_o <= RESET_LEVEL;
    end
    else
    begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff)
        level_o <= s3_ff;
    end
  end

  // Edges of the filtered level
  assign fall_o = level_o & ~s3_ff & ~s2_ff;
  assign rise_o = ~level_o & s3_ff & s2_ff;

endmodule

`default_nettype wire

// >>> core/ssc_step_ctrl.v
// Sequence step controller with AXI4-Lite register access
//
// Function
// - Step lasts its programmed duration before ending
// - Pause-after-step holds once duration elapses, unless phase align had to wait
// - Operator or external resume leaves pause hold
// - Step 0 ignores pause, jump, branch, finish settings
// - Phase align extends step until reference phase
// - Enabled jump goes to programmed target step
// - Jump counted limited times, infinite repeats forever; a pause step with nonzero count always jumps
// - Looped step without pause-after-step runs jump count plus one
// - Level branch jumps when external input active
// - Level input checked after duration, hold excluded
// - Edge branch on operator command or edge
// - Finish action continues or ends at step 0
// - Step code drives D3..D0 while step active
// - D0 optionally routed to sub output
// - External falling start edge starts when armed
// - External falling stop edge ends, goes step 0
// - Hold input pauses on fall, resumes on rise
// - Level branch input is active low
//
// The address map and the AXI4-Lite slave port are this design's own decisions.
`default_nettype none
`include "ssc_defines.vh"

module ssc_step_ctrl
#(
  parameter NSTEP = 16,
  parameter SW = 4,
  parameter [31:0] ID_VALUE = 32'h5a5a0001 // Arbitrary identification value
)
(
  // Clock and reset
  input wire core_clk_i,
  input wire srst_i,
  // AXI4-Lite write address
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Output phase from the waveform engine (same clock)
  input wire [7:0] phase_i,
  // External TTL control pins
  input wire ext_start_n_i,
  input wire ext_stop_n_i,
  input wire ext_hold_n_i,
  input wire ext_edge_branch_n_i,
  input wire ext_level_branch_n_i,
  // Step code and status outputs
  output reg [3:0] step_marker_output_o,
  output reg sub_out_o,
  output reg [SW-1:0] step_o,
  output reg running_o,
  output reg held_o
);

  // ---------------------------------------------------------------
  // States, one-hot
  // ---------------------------------------------------------------
  localparam [3:0] ST_ARMED = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_PHASE = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;

  // Step storage
  reg [31:0] time_mem [0:NSTEP-1];
  reg [31:0] cfg_mem [0:NSTEP-1];
  reg [7:0] loop_left_ff [0:NSTEP-1];
  reg [NSTEP-1:0] loop_act_ff;

  reg [3:0] state_ff;
  reg [SW-1:0] step_ff;
  reg [31:0] tcnt_ff;
  reg dur_done_ff;
  reg [1:0] ctrl_ff;
  reg [SW-1:0] sel_ff;
  reg [4:0] cmd_ff;

  // AXI holding registers
  reg aw_got_ff;
  reg w_got_ff;
  reg [11:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  wire start_fall;
  wire stop_fall;
  wire hold_fall;
  wire hold_rise;
  wire edge_fall;
  wire lvl_level;

  ssc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_start (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .pin_i(ext_start_n_i),
    .level_o(), .fall_o(start_fall), .rise_o());
  ssc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_stop (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .pin_i(ext_stop_n_i),
    .level_o(), .fall_o(stop_fall), .rise_o());
  ssc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_hold (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .pin_i(ext_hold_n_i),
    .level_o(), .fall_o(hold_fall), .rise_o(hold_rise));
  ssc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_edge (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .pin_i(ext_edge_branch_n_i),
    .level_o(), .fall_o(edge_fall), .rise_o());
  ssc_pin_sync #(.RESET_LEVEL(1'b1)) u_sync_lvl (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .pin_i(ext_level_branch_n_i),
    .level_o(lvl_level), .fall_o(), .rise_o());

  // ---------------------------------------------------------------
  // Event qualification
  // ---------------------------------------------------------------
  wire ext_en = ctrl_ff[`SSC_CTRL_EXT_EN];
  wire ev_start = cmd_ff[`SSC_CMD_START] | (ext_en & start_fall);
  wire ev_stop = cmd_ff[`SSC_CMD_STOP] | (ext_en & stop_fall);
  wire ev_hold = cmd_ff[`SSC_CMD_HOLD] | (ext_en & hold_fall);
  wire ev_resume = cmd_ff[`SSC_CMD_RESUME] | (ext_en & hold_rise);
  wire ev_edge = cmd_ff[`SSC_CMD_EVENT] | (ext_en & edge_fall);
  wire lvl_active = ext_en & ~lvl_level;

  // Current step settings; step 0 masks its sequencing options
  wire [31:0] cur_cfg = cfg_mem[step_ff];
  wire is_step0 = (step_ff == {SW{1'b0}});
  wire [31:0] eff_cfg = is_step0 ? (cur_cfg & 32'hffffff02) : cur_cfg;
  wire [SW-1:0] jump_tgt = eff_cfg[`SSC_CFG_JTGT_LSB +: SW];
  wire [SW-1:0] br_tgt = eff_cfg[`SSC_CFG_BTGT_LSB +: SW];
  wire [7:0] phs_ref = eff_cfg[`SSC_CFG_PHS_LSB +: 8];
  wire [3:0] jcnt = eff_cfg[`SSC_CFG_CNT_LSB +: 4];
  wire in_step = (state_ff != ST_ARMED);

  // ---------------------------------------------------------------
  // Step end decision
  // ---------------------------------------------------------------
  reg [SW-1:0] nxt_step;
  reg nxt_end;
  reg nxt_loop_take;
  reg nxt_loop_dec;
  always @*
  begin
    nxt_step = step_ff + {{(SW-1){1'b0}}, 1'b1};
    nxt_end = eff_cfg[`SSC_CFG_FIN_END];
    nxt_loop_take = 1'b0;
    nxt_loop_dec = 1'b0;
    if (eff_cfg[`SSC_CFG_LVL_EN] && lvl_active)
    begin
      nxt_step = br_tgt;
      nxt_end = 1'b0;
    end
    else if (eff_cfg[`SSC_CFG_JUMP_EN])
    begin
      if (!eff_cfg[`SSC_CFG_CNT_EN] || eff_cfg[`SSC_CFG_CNT_INF])
      begin
        nxt_step = jump_tgt;
        nxt_end = 1'b0;
      end
      else if (!loop_act_ff[step_ff] ? (jcnt != 4'h0) : (loop_left_ff[step_ff] != 8'h00))
      begin
        nxt_step = jump_tgt;
        nxt_end = 1'b0;
        nxt_loop_take = 1'b1;
        nxt_loop_dec = loop_act_ff[step_ff];
      end
    end
    if (nxt_end)
      nxt_step = {SW{1'b0}};
  end

  // ---------------------------------------------------------------
  // Sequencer state machine
  // ---------------------------------------------------------------
  wire dur_hit = (tcnt_ff + 32'h1 >= time_mem[step_ff]);
  integer i;
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      state_ff <= ST_ARMED;
      step_ff <= {SW{1'b0}};
      tcnt_ff <= 32'h0;
      dur_done_ff <= 1'b0;
      loop_act_ff <= {NSTEP{1'b0}};
      for (i = 0; i < NSTEP; i = i + 1)
        loop_left_ff[i] <= 8'h00;
    end
    else
    begin
      case (state_ff)
        ST_ARMED:
        begin
          if (ev_start)
          begin
            state_ff <= ST_RUN;
            tcnt_ff <= 32'h0;
            dur_done_ff <= 1'b0;
            loop_act_ff <= {NSTEP{1'b0}};
          end
        end
        ST_RUN, ST_PHASE:
        begin
          if (ev_stop)
          begin
            state_ff <= ST_ARMED;
            step_ff <= {SW{1'b0}};
          end
          else if (ev_hold)
          begin
            // The cycle in which hold is taken still ran, so it counts
            state_ff <= ST_HOLD;
            if (state_ff == ST_RUN && !dur_done_ff)
            begin
              tcnt_ff <= tcnt_ff + 32'h1;
              if (dur_hit)
                dur_done_ff <= 1'b1;
            end
          end
          else if (eff_cfg[`SSC_CFG_EDGE_EN] && ev_edge)
          begin
            step_ff <= br_tgt;
            state_ff <= ST_RUN;
            tcnt_ff <= 32'h0;
            dur_done_ff <= 1'b0;
          end
          else if (state_ff == ST_RUN && !dur_done_ff)
          begin
            tcnt_ff <= tcnt_ff + 32'h1;
            if (dur_hit)
              dur_done_ff <= 1'b1;
          end
          else if (eff_cfg[`SSC_CFG_PHASE_EN] && phase_i != phs_ref)
            state_ff <= ST_PHASE;
          else if (eff_cfg[`SSC_CFG_PAUSE] && state_ff == ST_RUN)
            state_ff <= ST_HOLD;
          else
          begin
            step_ff <= nxt_step;
            state_ff <= nxt_end ? ST_ARMED : ST_RUN;
            tcnt_ff <= 32'h0;
            dur_done_ff <= 1'b0;
            if (nxt_loop_take)
            begin
              loop_act_ff[step_ff] <= 1'b1;
              loop_left_ff[step_ff] <= nxt_loop_dec ?
                loop_left_ff[step_ff] - 8'h01 : {4'h0, jcnt} - 8'h01;
            end
            else
              loop_act_ff[step_ff] <= 1'b0; // Loop done, rearm count
          end
        end
        ST_HOLD:
        begin
          if (ev_stop)
          begin
            state_ff <= ST_ARMED;
            step_ff <= {SW{1'b0}};
          end
          else if (eff_cfg[`SSC_CFG_EDGE_EN] && ev_edge)
          begin
            step_ff <= br_tgt;
            state_ff <= ST_RUN;
            tcnt_ff <= 32'h0;
            dur_done_ff <= 1'b0;
          end
          else if (ev_resume)
          begin
            // Pause-after-step resumes into step end; plain hold resumes timing
            state_ff <= ST_RUN;
            if (dur_done_ff && eff_cfg[`SSC_CFG_PAUSE])
            begin
              step_ff <= nxt_step;
              state_ff <= nxt_end ? ST_ARMED : ST_RUN;
              tcnt_ff <= 32'h0;
              dur_done_ff <= 1'b0;
            end
          end
        end
        default: state_ff <= ST_ARMED;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Outputs from flip-flops
  // ---------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      step_marker_output_o <= 4'h0;
      sub_out_o <= 1'b0;
      step_o <= {SW{1'b0}};
      running_o <= 1'b0;
      held_o <= 1'b0;
    end
    else
    begin
      // Code tracks the active step's config, so it changes on transitions or on a CFG write to that step
      step_marker_output_o <= in_step ? cur_cfg[`SSC_CFG_CODE_LSB +: 4] : 4'h0;
      sub_out_o <= ctrl_ff[`SSC_CTRL_SUB_D0] & in_step & cur_cfg[`SSC_CFG_CODE_LSB];
      step_o <= step_ff;
      running_o <= (state_ff == ST_RUN) | (state_ff == ST_PHASE);
      held_o <= (state_ff == ST_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  wire wr_go = aw_got_ff & w_got_ff & ~s_axi_bvalid;
  integer j;
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 12'h000;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      ctrl_ff <= `SSC_RST_CTRL;
      sel_ff <= {SW{1'b0}};
      cmd_ff <= 5'h00;
      for (j = 0; j < NSTEP; j = j + 1)
      begin
        time_mem[j] <= `SSC_RST_TIME;
        cfg_mem[j] <= `SSC_RST_CFG;
      end
    end
    else
    begin
      cmd_ff <= 5'h00;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_ff <= s_axi_awaddr;
        aw_got_ff <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
        w_got_ff <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        case ({awaddr_ff[11:2], 2'b00})
          `SSC_OFS_CTRL: if (wstrb_ff[0]) ctrl_ff <= wdata_ff[1:0];
          `SSC_OFS_CMD: if (wstrb_ff[0]) cmd_ff <= wdata_ff[4:0];
          `SSC_OFS_SEL: if (wstrb_ff[0]) sel_ff <= wdata_ff[SW-1:0];
          `SSC_OFS_TIME: time_mem[sel_ff] <= wdata_ff;
          `SSC_OFS_CFG: cfg_mem[sel_ff] <= wdata_ff;
          default: s_axi_bresp <= 2'h2;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        case ({s_axi_araddr[11:2], 2'b00})
          `SSC_OFS_CTRL: s_axi_rdata <= {30'h0, ctrl_ff};
          `SSC_OFS_STATUS: s_axi_rdata <= {20'h0, state_ff, {(8-SW){1'b0}}, step_ff};
          `SSC_OFS_CMD: s_axi_rdata <= 32'h0;
          `SSC_OFS_SEL: s_axi_rdata <= {{(32-SW){1'b0}}, sel_ff};
          `SSC_OFS_TIME: s_axi_rdata <= time_mem[sel_ff];
          `SSC_OFS_CFG: s_axi_rdata <= cfg_mem[sel_ff];
          `SSC_OFS_PHASE_NOW: s_axi_rdata <= {24'h0, phase_i};
          `SSC_OFS_ID: s_axi_rdata <= ID_VALUE;
          default:
          begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// >>> test/ssc_ext_model.sv
// External test equipment driving the TTL control pins
`default_nettype none
module ssc_ext_model
(
  // Clock used to pace pin changes
  input wire logic core_clk_i,
  // Pins: 0 start, 1 stop, 2 hold, 3 edge branch, 4 level branch
  output logic [4:0] pins_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // All pins idle high (inactive) until driven
  initial pins_n_o = 5'h1f;
  // Sets one pin level just after an edge; falls are start/stop/hold/edge, low level branches
  task automatic drive(input int idx, input logic lvl);
    @(posedge core_clk_i);
    pins_n_o[idx] <= lvl;
  endtask
endmodule
`default_nettype wire

// >>> test/ssc_step_ctrl_chk.sv
// Port-level checker for the sequence step controller
`default_nettype none
module ssc_step_ctrl_chk
#(
  parameter SW = 4
)
(
  // Clock and reset
  input wire logic core_clk_i, srst_i,
  // Bus handshakes
  input wire logic s_axi_awready, s_axi_bvalid, s_axi_bready,
  input wire logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
  // Sequencer outputs
  input wire logic [3:0] step_marker_output_o,
  input wire logic [SW-1:0] step_o,
  input wire logic sub_out_o, running_o, held_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Write answer stands, read answer follows next cycle; pending answers block new requests
  a_bvalid_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  a_rvalid_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write taken while answer pending");
  // Sequencer state and outputs
  a_hold_not_run: assert property (held_o |-> !running_o && (!$past(held_o) || $stable(step_o)))
    else $error("hold and run together");
  a_sub_copies_d0: assert property (sub_out_o |-> step_marker_output_o[0])
    else $error("sub output without code bit");
  a_code_at_step: assert property (!$stable(step_marker_output_o) |-> !$stable(step_o) ||
    !$stable(running_o) || !$stable(held_o))
    else $error("step code changed inside a step");
  a_armed_home: assert property ((!running_o && !held_o) [*3] |->
    step_o == 0 && step_marker_output_o == 4'h0)
    else $error("armed away from step 0");
endmodule
bind ssc_step_ctrl ssc_step_ctrl_chk #(.SW(SW)) u_chk (.core_clk_i(core_clk_i),
  .srst_i(srst_i), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .step_o(step_o),
  .step_marker_output_o(step_marker_output_o), .sub_out_o(sub_out_o),
  .running_o(running_o), .held_o(held_o));
`default_nettype wire

// >>> test/tb_ssc_step_ctrl.sv
// Self-checking testbench for the sequence step controller
`default_nettype none
`include "ssc_defines.vh"
module tb_ssc_step_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] ID = 32'h12340abc; // Arbitrary identification value
  logic clk, srst = 1'b1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, d;
  logic [1:0] bresp, rresp, rsp;
  logic awready, wready, bvalid, arready, rvalid, sub, running, held;
  logic [3:0] marker, step, pstep = 0;
  logic [7:0] phase = 0, ph_at = 0;
  logic [4:0] pins;
  int n_mismatch = 0, samples_checked = 0, cyc[16];
  // ------------------------------------------------------------
  // Clock, phase source, monitor
  // ------------------------------------------------------------
  initial begin clk = 0; forever #12.5 clk = ~clk; end
  always @(posedge clk) phase <= phase + 8'h01;
  // Counts running cycles per step and notes phase on entry to step 1
  always @(posedge clk)
  begin
    if (running === 1'b1) cyc[step] = cyc[step] + 1;
    if (step === 4'h1 && pstep === 4'h0) ph_at <= phase;
    pstep <= step;
  end
  ssc_ext_model ext (.core_clk_i(clk), .pins_n_o(pins));
  ssc_step_ctrl #(.ID_VALUE(ID)) uut (.core_clk_i(clk), .srst_i(srst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .phase_i(phase),
    .ext_start_n_i(pins[0]), .ext_stop_n_i(pins[1]), .ext_hold_n_i(pins[2]),
    .ext_edge_branch_n_i(pins[3]), .ext_level_branch_n_i(pins[4]),
    .step_marker_output_o(marker), .sub_out_o(sub), .step_o(step), .running_o(running),
    .held_o(held));
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, exp, got); end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge clk);
    awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge clk);
      if (awready === 1'b1) awvalid <= 0;
      if (wready === 1'b1) wvalid <= 0;
    end while (bvalid !== 1'b1);
    bready <= 0; awvalid <= 0; wvalid <= 0; rsp = bresp;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    do begin
      @(posedge clk);
      if (arready === 1'b1) arvalid <= 0;
    end while (rvalid !== 1'b1);
    rready <= 0; arvalid <= 0; d = rdata; rsp = rresp;
  endtask
  task automatic prog(input logic [31:0] s, input logic [31:0] tm, input logic [31:0] c);
    wr(`SSC_OFS_SEL, s); wr(`SSC_OFS_TIME, tm); wr(`SSC_OFS_CFG, c);
  endtask
  task automatic wait_step(input logic [3:0] s);
    int t;
    for (t = 0; t < 2000 && step !== s; t++) @(posedge clk);
    if (step !== s) chk("wait step", s, step);
    @(posedge clk);
  endtask
  task automatic wait_armed;
    int t;
    for (t = 0; t < 2000 && (running !== 1'b0 || held !== 1'b0); t++) @(posedge clk);
    if (running !== 1'b0 || held !== 1'b0) chk("wait armed", 0, {running, held});
    repeat (3) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (n_mismatch == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic sc_reset;
    rd(`SSC_OFS_TIME); chk("time reset", `SSC_RST_TIME, d);
    rd(`SSC_OFS_CFG); chk("cfg reset", `SSC_RST_CFG, d);
    rd(`SSC_OFS_CTRL); chk("ctrl reset", 32'h0, d);
    rd(`SSC_OFS_ID); chk("id", ID, d);
    rd(`SSC_OFS_STATUS); chk("status reset", 32'h100, d);
    rd(12'h100); chk("unmapped rresp", 2'h2, rsp);
    wr(12'h100, 32'h1); chk("unmapped bresp", 2'h2, rsp);
  endtask
  // Phase-aligned step 0, looped step 1 (count 2), ending step 2
  task automatic sc_loop;
    prog(0, 8, {8'd40, 4'h0, 4'h0, 4'h0, 4'h1, 8'h02});
    prog(1, 3, {8'h00, 4'h2, 4'h0, 4'h1, 4'h2, 8'h0c});
    prog(2, 2, {8'h00, 4'h0, 4'h0, 4'h0, 4'h3, 8'h80});
    foreach (cyc[i]) cyc[i] = 0;
    wr(`SSC_OFS_CMD, 32'h1);
    wait_step(2);
    chk("code step2", 4'h3, marker);
    wait_armed;
    chk("phase at end", 1'b1, (ph_at - 8'd41) < 8'd4);
    chk("loop cycles", 32'd12, cyc[1]);
    chk("step2 cycles", 32'd3, cyc[2]);
    chk("end step", 4'h0, step);
  endtask
  // Step 0 ignores pause and End; step 1 pauses until resumed
  task automatic sc_pause;
    int t;
    prog(0, 2, {8'h00, 4'h0, 4'h0, 4'h0, 4'h4, 8'h81});
    prog(1, 5, {8'h00, 4'h0, 4'h0, 4'h0, 4'h5, 8'h81});
    wr(`SSC_OFS_CMD, 32'h1);
    for (t = 0; t < 200 && held !== 1'b1; t++) @(posedge clk);
    chk("pause step", 4'h1, step);
    repeat (20) @(posedge clk);
    chk("still held", 1'b1, held);
    chk("code in hold", 4'h5, marker);
    wr(`SSC_OFS_CMD, 32'h8);
    wait_armed;
    chk("after resume", 4'h0, step);
    // Operator hold, event branch and stop commands
    prog(1, 300, {8'h00, 4'h0, 4'h2, 4'h0, 4'h5, 8'h40});
    wr(`SSC_OFS_CMD, 32'h1);
    wait_step(1);
    wr(`SSC_OFS_CMD, 32'h4);
    repeat (2) @(posedge clk);
    chk("cmd hold", 1'b1, held);
    wr(`SSC_OFS_CMD, 32'h10);
    wait_step(2);
    chk("cmd event", 4'h3, marker);
    wait_armed;
    foreach (cyc[i]) cyc[i] = 0;
    wr(`SSC_OFS_CMD, 32'h1);
    wait_step(1);
    wr(`SSC_OFS_CMD, 32'h2);
    wait_armed;
    chk("cmd stop", 1'b1, cyc[2] == 0 && step == 4'h0);
  endtask
  // External start, hold, level and edge branch, ignored start, stop
  task automatic sc_ext;
    wr(`SSC_OFS_CTRL, 32'h3);
    prog(0, 3, {8'h00, 4'h0, 4'h0, 4'h0, 4'h1, 8'h00});
    prog(1, 20, {8'h00, 4'h0, 4'h3, 4'h0, 4'h7, 8'h20});
    prog(3, 200, {8'h00, 4'h0, 4'h5, 4'h0, 4'h9, 8'h40});
    prog(5, 2, {8'h00, 4'h0, 4'h0, 4'h0, 4'hb, 8'h80});
    foreach (cyc[i]) cyc[i] = 0;
    ext.drive(4, 0);
    ext.drive(0, 0);
    wait_step(1);
    ext.drive(2, 0);
    repeat (30) @(posedge clk);
    chk("ext hold", 1'b1, held);
    ext.drive(2, 1);
    wait_step(3);
    chk("level branch time", 32'd21, cyc[1]);
    chk("sub out", 1'b1, sub);
    ext.drive(0, 1);
    repeat (5) @(posedge clk);
    ext.drive(0, 0);
    repeat (10) @(posedge clk);
    chk("start ignored", 4'h3, step);
    ext.drive(3, 0);
    wait_step(5);
    chk("edge branch", 1'b1, cyc[3] < 100);
    wait_armed;
    ext.drive(3, 1); ext.drive(4, 1); ext.drive(0, 1);
    repeat (5) @(posedge clk);
    ext.drive(0, 0);
    wait_step(1);
    ext.drive(1, 0);
    wait_armed;
    chk("ext stop", 4'h0, step);
    chk("stop before end", 1'b1, cyc[2] == 0);
  endtask
  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    sc_reset;
    sc_loop;
    sc_pause;
    sc_ext;
    end_of_test;
  end
  initial
  begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
